/* plc_dev.sv */
// Device end: configuration bank for the upper four control words.
// Assumes serial pins come from another domain and are synchronised.
`timescale 1ns/100ps
`default_nettype none
module plc_dev
  import plc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  plc_ser_if.dev ser,
  input wire logic [5:0] band_cal_result,
  input wire logic [7:0] status_sources,
  output logic [23:0] cp_word,
  output logic [23:0] lo_word,
  output logic [23:0] vco_word,
  output logic [23:0] ext_word,
  output logic [9:0] cp_nominal_ua,
  output logic cp_trim_resistor,
  output logic [12:0] pfd_offset_tenth_deg,
  output logic pfd_offset_negative,
  output logic [1:0] ref_scale_sel,
  output logic status_mux_output,
  output logic mod_bias_en,
  output logic mod_out_en,
  output logic lo_port_is_input,
  output logic lo_port_drive_on,
  output logic lo_port_double,
  output logic lo_input_is_4x,
  output logic [5:0] vco_band_used,
  output logic [5:0] vco_amplitude,
  output logic cp_enable,
  output logic [2:0] vco_enables,
  output logic pll_shutdown,
  output logic int_vco_off,
  output logic second_lo_divider_bypass
);
  // ----------------------------------------------------------
  // Pin synchronisers, change accepted when stages 2 and 3 agree
  // ----------------------------------------------------------
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] sync3_reg;
  logic [3:0] pin_reg;
  logic [3:0] pin_prev_reg;
  logic sclk_rise;
  logic latch_rise;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      sync3_reg <= 4'h0;
      pin_reg <= 4'h0;
      pin_prev_reg <= 4'h0;
    end
    else
    begin
      sync1_reg <= {ser.lo_port_select_pin, ser.ser_latch,
                    ser.ser_data, ser.ser_clk};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      for (int i = 0; i < 4; i++)
        if (sync2_reg[i] == sync3_reg[i])
          pin_reg[i] <= sync3_reg[i];
      pin_prev_reg <= pin_reg;
    end
  end

  assign sclk_rise = pin_reg[0] && !pin_prev_reg[0];
  assign latch_rise = pin_reg[2] && !pin_prev_reg[2];

  // ----------------------------------------------------------
  // Shift register and word commit
  // ----------------------------------------------------------
  logic [23:0] shift_reg;
  logic [4:0] cnt_reg;
  logic commit;

  // Extra bits saturate the count so an overlong word is refused
  assign commit = latch_rise && (cnt_reg == BITS_PER_WORD);

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      shift_reg <= 24'h0;
      cnt_reg <= 5'h0;
    end
    else if (latch_rise)
      cnt_reg <= 5'h0;
    else if (sclk_rise)
    begin
      shift_reg <= {shift_reg[22:0], pin_reg[1]};
      if (cnt_reg != 5'h1f)
        cnt_reg <= cnt_reg + 5'h1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cp_word <= RST_CP;
      lo_word <= RST_LO;
      vco_word <= RST_VCO;
      ext_word <= RST_EXT;
    end
    else if (commit)
    begin
      if (shift_reg[2:0] == ADDR_CP)
        cp_word <= shift_reg;
      else if (shift_reg[2:0] == ADDR_LO)
        lo_word <= shift_reg;
      else if (shift_reg[2:0] == ADDR_VCO)
        vco_word <= shift_reg;
      else if (shift_reg[2:0] == ADDR_EXT)
        ext_word <= shift_reg;
    end
  end

  // ----------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------
  function automatic logic [9:0] plc_cp_ua(input logic [1:0] code);
    plc_cp_ua = 10'({2'h0, code} + 4'h1) * CP_UA_STEP;
  endfunction

  logic [2:0] mux_sel;
  logic lo_sel;
  logic lo_in;
  assign mux_sel = cp_word[CP_MUX_LSB +: 3];
  assign lo_sel = pin_reg[3];
  assign lo_in = !lo_sel && lo_word[LO_XL_BIT];

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cp_nominal_ua <= 10'h0;
      cp_trim_resistor <= 1'b0;
      pfd_offset_tenth_deg <= 13'h0000;
      pfd_offset_negative <= 1'b0;
      ref_scale_sel <= 2'h0;
      status_mux_output <= 1'b0;
    end
    else
    begin
      // Current step set by the code; trim only rescales it
      cp_nominal_ua <= plc_cp_ua(cp_word[CP_CUR_LSB +: 2]);
      cp_trim_resistor <= cp_word[CP_TRIM_BIT];
      pfd_offset_tenth_deg <=
        13'({8'h0, cp_word[CP_OFS_LSB +: 5]} * OFS_TENTH_DEG);
      pfd_offset_negative <= cp_word[CP_SIGN_BIT];
      ref_scale_sel <= cp_word[CP_REF_LSB +: 2];
      status_mux_output <= status_sources[mux_sel];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      mod_bias_en <= 1'b0;
      mod_out_en <= 1'b0;
      lo_port_is_input <= 1'b0;
      lo_port_drive_on <= 1'b0;
      lo_port_double <= 1'b0;
      lo_input_is_4x <= 1'b0;
      second_lo_divider_bypass <= 1'b0;
    end
    else
    begin
      mod_bias_en <= lo_word[MOD_BIAS_BIT];
      mod_out_en <= lo_word[MOD_BIAS_BIT] && lo_word[MOD_OUT_BIT];
      lo_port_is_input <= lo_in;
      lo_input_is_4x <= lo_in && !ext_word[EXT_DIV2_BIT];
      lo_port_drive_on <= !lo_word[LO_XL_BIT]
                          && (lo_sel || lo_word[LO_DRV_BIT]);
      lo_port_double <= !lo_word[LO_XL_BIT] && lo_word[LO_DBL_BIT];
      second_lo_divider_bypass <= ext_word[EXT_DIV2_BIT];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      vco_band_used <= 6'h0;
      vco_amplitude <= 6'h0;
      cp_enable <= 1'b0;
      vco_enables <= 3'h0;
      pll_shutdown <= 1'b0;
      int_vco_off <= 1'b0;
    end
    else
    begin
      vco_band_used <= vco_word[VCO_BSRC_BIT]
                       ? vco_word[VCO_BAND_LSB +: 6]
                       : band_cal_result;
      vco_amplitude <= vco_word[VCO_AMP_LSB +: 6];
      cp_enable <= vco_word[VCO_CP_EN_BIT];
      vco_enables <= vco_word[VCO_EN_LSB +: 3];
      pll_shutdown <= (vco_word[VCO_EN_LSB +: 4] == 4'h0);
      int_vco_off <= ext_word[EXT_VCO_BIT]
                     && (vco_word[VCO_AMP_LSB +: 6] == 6'h0);
    end
  end
endmodule
`default_nettype wire

/* plc_pkg.sv */
// Shared constants for the synthesizer configuration bank and its host.
// Assumes one system clock and a three-wire serial programming port.
`default_nettype none
package plc_pkg;
  // ----------------------------------------------------------
  // Serial word layout
  // ----------------------------------------------------------
  localparam int WORD_W = 24;
  localparam int ADDR_W = 3;
  localparam logic [2:0] ADDR_CP = 3'h4;
  localparam logic [2:0] ADDR_LO = 3'h5;
  localparam logic [2:0] ADDR_VCO = 3'h6;
  localparam logic [2:0] ADDR_EXT = 3'h7;
  localparam logic [23:0] RST_CP = 24'h12a7e4;
  localparam logic [23:0] RST_LO = 24'h0000e5;
  localparam logic [23:0] RST_VCO = 24'h1e2106;
  localparam logic [23:0] RST_EXT = 24'h000007;
  // ----------------------------------------------------------
  // Charge pump, phase detector and reference word
  // ----------------------------------------------------------
  localparam int CP_CUR_LSB = 10;
  localparam int CP_OFS_LSB = 12;
  localparam int CP_SIGN_BIT = 17;
  localparam int CP_TRIM_BIT = 18;
  localparam int CP_REF_LSB = 19;
  localparam int CP_MUX_LSB = 21;
  localparam logic [2:0] MUX_LOCK_DETECT = 3'h0;
  localparam logic [9:0] CP_UA_STEP = 10'h0fa;
  // Wide enough for the largest multiplier, 31 steps of 22.5 degrees
  localparam logic [12:0] OFS_TENTH_DEG = 13'h00e1;
  // ----------------------------------------------------------
  // LO path and modulator word
  // ----------------------------------------------------------
  localparam int LO_DRV_BIT = 3;
  localparam int LO_XL_BIT = 4;
  localparam int LO_DBL_BIT = 5;
  localparam int MOD_OUT_BIT = 6;
  localparam int MOD_BIAS_BIT = 7;
  // ----------------------------------------------------------
  // VCO word and external VCO word
  // ----------------------------------------------------------
  localparam int VCO_BAND_LSB = 3;
  localparam int VCO_BSRC_BIT = 9;
  localparam int VCO_AMP_LSB = 10;
  localparam int VCO_EN_LSB = 17;
  localparam int VCO_CP_EN_BIT = 20;
  localparam int EXT_DIV2_BIT = 4;
  localparam int EXT_VCO_BIT = 22;
  // ----------------------------------------------------------
  // Host register map and serial timing
  // ----------------------------------------------------------
  localparam logic [11:0] HOST_DATA_OFS = 12'h000;
  localparam logic [11:0] HOST_CTRL_OFS = 12'h004;
  localparam logic [11:0] HOST_STAT_OFS = 12'h008;
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_SEL_BIT = 1;
  localparam int CLK_PERIOD_NS = 25;
  localparam int SCLK_HALF_NS = 100;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam logic [4:0] BITS_PER_WORD = 5'h18;
endpackage
`default_nettype wire

/* plc_ser_if.sv */
// Serial programming port between host and configuration bank.
// Assumes both ends run on the same system clock in the bench.
`timescale 1ns/100ps
`default_nettype none
interface plc_ser_if;
  logic ser_clk;
  logic ser_data;
  logic ser_latch;
  logic lo_port_select_pin;
  modport host (output ser_clk, output ser_data, output ser_latch,
                output lo_port_select_pin);
  modport dev (input ser_clk, input ser_data, input ser_latch,
               input lo_port_select_pin);
endinterface
`default_nettype wire

/* plc_host.sv */
// Host end: APB slave that shifts 24-bit words out, MSB first.
// Assumes the device samples data on the rising serial clock edge.
`timescale 1ns/100ps
`default_nettype none
module plc_host
  import plc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  plc_ser_if.host ser
);
  typedef enum logic [3:0]
  {
    ST_IDLE = 4'h1,
    ST_LOW = 4'h2,
    ST_HIGH = 4'h4,
    ST_LATCH = 4'h8
  } plc_hst_e;

  plc_hst_e state_reg;
  logic [23:0] data_reg;
  logic [23:0] shift_reg;
  logic sel_reg;
  logic [4:0] bit_cnt_reg;
  logic [7:0] div_reg;
  logic tick;
  logic go;
  logic busy;

  assign busy = (state_reg != ST_IDLE);
  assign tick = (div_reg == 8'(SCLK_HALF_CYC - 1));
  assign go = psel && penable && pwrite && (paddr == HOST_CTRL_OFS)
              && pwdata[CTRL_GO_BIT] && !busy;

  // ----------------------------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      if (psel && !penable)
      begin
        if (paddr == HOST_DATA_OFS)
          prdata <= {8'h0, data_reg};
        else if (paddr == HOST_CTRL_OFS)
          prdata <= {30'h0, sel_reg, 1'b0};
        else if (paddr == HOST_STAT_OFS)
          prdata <= {26'h0, bit_cnt_reg, busy};
        else
          pslverr <= 1'b1;
      end
    end
  end

  // Writes to the data word during a shift are dropped
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      data_reg <= 24'h0;
      sel_reg <= 1'b0;
    end
    else if (psel && penable && pready && pwrite)
    begin
      if (paddr == HOST_DATA_OFS && !busy)
        data_reg <= pwdata[23:0];
      else if (paddr == HOST_CTRL_OFS)
        sel_reg <= pwdata[CTRL_SEL_BIT];
    end
  end

  // ----------------------------------------------------------
  // Serial engine
  // ----------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || !busy)
      div_reg <= 8'h0;
    else if (tick)
      div_reg <= 8'h0;
    else
      div_reg <= div_reg + 8'h1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state_reg <= ST_IDLE;
      shift_reg <= 24'h0;
      bit_cnt_reg <= 5'h0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (go && pready)
          begin
            shift_reg <= data_reg;
            bit_cnt_reg <= 5'h0;
            state_reg <= ST_LOW;
          end
        end
        ST_LOW:
          if (tick)
            state_reg <= ST_HIGH;
        ST_HIGH:
        begin
          if (tick)
          begin
            shift_reg <= {shift_reg[22:0], 1'b0};
            bit_cnt_reg <= bit_cnt_reg + 5'h1;
            // Latch pulses only after a whole word
            if (bit_cnt_reg == BITS_PER_WORD - 5'h1)
              state_reg <= ST_LATCH;
            else
              state_reg <= ST_LOW;
          end
        end
        ST_LATCH:
          if (tick)
            state_reg <= ST_IDLE;
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // Serial pins, select pin always driven to a level
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      ser.ser_clk <= 1'b0;
      ser.ser_data <= 1'b0;
      ser.ser_latch <= 1'b0;
      ser.lo_port_select_pin <= 1'b0;
    end
    else
    begin
      ser.ser_clk <= (state_reg == ST_HIGH);
      ser.ser_data <= (state_reg == ST_LOW || state_reg == ST_HIGH)
                      ? shift_reg[23] : 1'b0;
      ser.ser_latch <= (state_reg == ST_LATCH);
      ser.lo_port_select_pin <= sel_reg;
    end
  end
endmodule
`default_nettype wire

/* plc_dev_note_end.sv */
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

/* plc_ser_chk.sv */
// Checker for the serial programming port between host and bank.
// Assumes one clock; sees only the interface wires and clock/reset.
`timescale 1ns/100ps
`default_nettype none
module plc_ser_chk
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_latch,
  input wire logic lo_port_select_pin
);
  // ----------------------------------------------------------
  // Rise counter per frame
  // ----------------------------------------------------------
  logic [5:0] rise_cnt_reg;
  logic clk_prev_reg;
  always_ff @(posedge clk_sys)
  begin
    clk_prev_reg <= sys_rst ? 1'b0 : ser_clk;
  end
  // Cleared by latch so an overlong word shows up as a 25th rise
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || ser_latch)
      rise_cnt_reg <= 6'h00;
    else if (ser_clk && !clk_prev_reg)
      rise_cnt_reg <= rise_cnt_reg + 6'h01;
  end
  // ----------------------------------------------------------
  // Wire properties
  // ----------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_hold_high;
    ser_clk [*4] ##1 !ser_clk;
  endsequence
  sequence s_hold_low;
    !ser_clk [*4];
  endsequence
  sequence s_latch_pulse;
    ser_latch [*4] ##1 !ser_latch;
  endsequence
  a_clk_high_width: assert property ($rose(ser_clk) |-> s_hold_high)
    else $error("serial clock high phase wrong length");
  a_clk_low_width: assert property ($fell(ser_clk) |-> s_hold_low)
    else $error("serial clock low phase too short");
  a_data_stable: assert property (ser_clk |-> $stable(ser_data))
    else $error("serial data moved while clock high");
  a_latch_width: assert property
    ($rose(ser_latch) |-> s_latch_pulse)
    else $error("latch pulse wrong length");
  a_latch_clk_low: assert property (ser_latch |-> !ser_clk)
    else $error("serial clock high during latch");
  a_word_count: assert property
    ($rose(ser_latch) |-> rise_cnt_reg == 6'h18)
    else $error("latch without exactly 24 bits");
  a_latch_after_word: assert property
    (rise_cnt_reg == 6'h18 && $fell(ser_clk) |-> $rose(ser_latch))
    else $error("no latch after full word");
  a_no_extra_rise: assert property
    (rise_cnt_reg == 6'h18 |-> !$rose(ser_clk))
    else $error("more than 24 bits in a word");
  a_rst_idle: assert property
    ($fell(sys_rst) |-> !ser_clk && !ser_latch && !lo_port_select_pin)
    else $error("port wires not idle after reset");
endmodule
`default_nettype wire

/* pll_lo_path_config_regs_tb_top.sv */
// Bench: APB into the host end, serial link into the bank end.
// Assumes one 40 MHz clock; an integer model predicts every bank word and decoded output.
`timescale 1ns/100ps
`default_nettype none
module pll_lo_path_config_regs_tb_top
  import plc_pkg::*;
;
  // ----------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------
  logic clk_sys = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, sel_m;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [5:0] band_cal_result = 6'h00, vco_band_used, vco_amplitude;
  logic [7:0] status_sources = 8'h01;
  logic [23:0] cp_word, lo_word, vco_word, ext_word;
  logic [9:0] cp_nominal_ua;
  logic [12:0] pfd_offset_tenth_deg;
  logic [2:0] vco_enables;
  logic [1:0] ref_scale_sel;
  logic cp_trim_resistor, pfd_offset_negative, status_mux_output;
  logic mod_bias_en, mod_out_en, lo_port_is_input, lo_port_drive_on;
  logic lo_port_double, lo_input_is_4x, cp_enable, pll_shutdown;
  logic int_vco_off, second_lo_divider_bypass;
  int m[8], cyc = 0, miscompares = 0, checks = 0;
  plc_ser_if ser_bus();
  plc_host plc_host_i (.clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ser(ser_bus));
  plc_dev plc_dev_i (.clk_sys, .sys_rst, .ser(ser_bus), .band_cal_result,
    .status_sources, .cp_word, .lo_word, .vco_word, .ext_word, .cp_nominal_ua,
    .cp_trim_resistor, .pfd_offset_tenth_deg, .pfd_offset_negative,
    .ref_scale_sel, .status_mux_output, .mod_bias_en, .mod_out_en,
    .lo_port_is_input, .lo_port_drive_on, .lo_port_double, .lo_input_is_4x,
    .vco_band_used, .vco_amplitude, .cp_enable, .vco_enables, .pll_shutdown,
    .int_vco_off, .second_lo_divider_bypass);
  plc_ser_chk plc_ser_chk_i (.clk_sys, .sys_rst, .ser_clk(ser_bus.ser_clk),
    .ser_data(ser_bus.ser_data), .ser_latch(ser_bus.ser_latch),
    .lo_port_select_pin(ser_bus.lo_port_select_pin));
  wire logic [52:0] got_d = {cp_nominal_ua, cp_trim_resistor,
    pfd_offset_tenth_deg, pfd_offset_negative, ref_scale_sel,
    status_mux_output, mod_bias_en, mod_out_en, lo_port_is_input,
    lo_port_drive_on, lo_port_double, lo_input_is_4x, vco_band_used,
    vco_amplitude, cp_enable, vco_enables, pll_shutdown, int_vco_off,
    second_lo_divider_bypass};
  initial
  begin
    forever #12.5 clk_sys = !clk_sys;
  end
  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  task automatic chk(input string nm, input logic [99:0] e,
                     input logic [99:0] g);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic end_sim();
    if (miscompares == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic reset_model();
    m = '{0, 0, 0, 0, int'(RST_CP), int'(RST_LO),
          int'(RST_VCO), int'(RST_EXT)};
    sel_m = 1'b0;
  endtask
  // Request held until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so a following call never re-raises psel in this step
    @(posedge clk_sys);
  endtask
  task automatic check_all();
    logic [23:0] c, l, v, x;
    logic [52:0] d;
    c = m[4][23:0];
    l = m[5][23:0];
    v = m[6][23:0];
    x = m[7][23:0];
    d = {(10'(c[11:10]) + 10'h001) * CP_UA_STEP, c[18],
      13'(c[16:12]) * OFS_TENTH_DEG, c[17], c[20:19],
      status_sources[c[23:21]], l[7], l[7] & l[6], !sel_m & l[4],
      !l[4] & (sel_m | l[3]), !l[4] & l[5], !sel_m & l[4] & !x[4],
      v[9] ? v[8:3] : band_cal_result, v[15:10], v[20], v[19:17],
      v[20:17] == 4'h0, x[22] & (v[15:10] == 6'h00), x[4]};
    chk("words", {c, l, v, x},
        {cp_word, lo_word, vco_word, ext_word});
    chk("cp_cur", d[52:42], got_d[52:42]);
    chk("pfd_ref", d[41:25], got_d[41:25]);
    chk("lo_dec", d[24:19], got_d[24:19]);
    chk("vco_dec", d[18:0], got_d[18:0]);
  endtask
  // Optional second word and go mid-frame must both be ignored
  task automatic send(input logic [23:0] w, input logic s, input logic dup);
    logic [31:0] r;
    logic e;
    int n;
    band_cal_result <= 6'($urandom());
    status_sources <= 8'($urandom());
    apb(1'b1, HOST_DATA_OFS, {8'h00, w}, r, e);
    apb(1'b1, HOST_CTRL_OFS, {30'h0, s, 1'b1}, r, e);
    if (dup)
    begin
      apb(1'b1, HOST_DATA_OFS, 32'h00ffffff, r, e);
      apb(1'b1, HOST_CTRL_OFS, {30'h0, s, 1'b1}, r, e);
    end
    n = 0;
    r = 32'h1;
    while (r[0] !== 1'b0 && n < 300)
    begin
      apb(1'b0, HOST_STAT_OFS, 32'h0, r, e);
      n++;
    end
    // A poll that runs out counts as a mismatch here
    chk("busy_end", 1'b0, r[0]);
    if (dup)
    begin
      apb(1'b0, HOST_DATA_OFS, 32'h0, r, e);
      chk("data_kept", {1'b0, 8'h00, w}, {e, r});
    end
    repeat (8) @(posedge clk_sys);
    sel_m = s;
    if (w[2:0] >= ADDR_CP)
      m[w[2:0]] = int'(w);
    check_all();
  endtask
  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      miscompares++;
      end_sim();
    end
  end
  initial
  begin
    logic [31:0] r;
    logic e;
    void'($urandom(5470));
    reset_model();
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check_all();
    apb(1'b1, HOST_DATA_OFS, 32'hffa5c3e1, r, e);
    apb(1'b0, HOST_DATA_OFS, 32'h0, r, e);
    chk("data_rd", {1'b0, 32'h00a5c3e1}, {e, r});
    apb(1'b0, HOST_CTRL_OFS, 32'h0, r, e);
    chk("go_rd", 2'h0, {e, r[0]});
    apb(1'b1, 12'h00c, 32'h0, r, e);
    chk("unmapped", 1'b1, e);
    send((RST_CP & 24'hfe0fff) | 24'h006000, 1'b0, 1'b1);
    send(RST_VCO | 24'h00fc00, 1'b0, 1'b0);
    send(RST_VCO & 24'he1ffff, 1'b0, 1'b0);
    send(RST_VCO & 24'hff03ff, 1'b0, 1'b0);
    for (int k = 0; k < 32; k++)
    begin
      if (k[3:0] == 4'h0)
        send(24'h400007 | (k[4] ? 24'h000010 : 24'h0), 1'b0, 1'b0);
      send(24'h0000c5 | 24'({k[2:0], 3'h0}), k[3], 1'b0);
    end
    for (int i = 0; i < 24; i++)
      send(24'($urandom()), 1'($urandom()), 1'b0);
    // Reset mid-frame: the cut word must not land anywhere
    apb(1'b1, HOST_DATA_OFS, 32'h00000004, r, e);
    apb(1'b1, HOST_CTRL_OFS, 32'h00000003, r, e);
    repeat (40) @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    reset_model();
    repeat (3) @(posedge clk_sys);
    check_all();
    apb(1'b0, HOST_STAT_OFS, 32'h0, r, e);
    chk("stat_rst", 33'h0, {e, r});
    end_sim();
  end
endmodule
`default_nettype wire
